// ### src/mitc_pkg.sv
// package: constants, opcode set and field layout of the instruction timing core
// What this block does
// - four clocks form one instruction cycle
// - most one cycle; branch, call, table two
// - jump, call, returns take one extra cycle
// - writing program counter low byte jumps, extra cycle
// - taken skip costs one extra cycle
// - 8-bit add carry, subtract borrow
// - increment/decrement by one, memory or accumulator
// - logical results set zero flag when zero
// - rotate by one, through-carry variants use carry
// - call saves next address for return
// - conditional test skips or runs next instruction
// - bit set/clear touches only selected bit
// - table read fetches program memory data
// - three data transfer forms supported
// - add/subtract update zero, carry, aux, overflow
package mitc_pkg;
  // ==========================================================
  // timing and widths
  localparam int         CYCLE_CLKS  = 4;
  localparam logic [1:0] PHASE_FIRST = 2'h0;
  localparam logic [1:0] PHASE_LAST  = 2'(CYCLE_CLKS - 1);
  localparam int         PC_W        = 11;
  localparam int         DATA_W      = 8;
  localparam int         INSTR_W     = 17;
  localparam int         MEM_AW      = 6;
  localparam int         MEM_DEPTH   = 64;
  localparam int         STACK_DEPTH = 4;
  // ==========================================================
  // instruction fields
  localparam int OP_LSB   = 11;
  localparam int DEST_POS = 8;
  localparam int BIT_LSB  = 8;
  // ==========================================================
  // data memory map and reset values
  localparam logic [5:0]  ADDR_PROGRAM_COUNTER_LOW_BYTE = 6'h02;
  localparam logic [5:0]  ADDR_TABLE_PTR  = 6'h07;
  localparam logic [5:0]  ADDR_TABLE_HIGH = 6'h08;
  localparam logic [5:0]  ADDR_PORT       = 6'h12;
  localparam logic [2:0]  TABLE_PAGE      = 3'h7;
  localparam logic [10:0] PC_RESET        = 11'h000;
  localparam logic [7:0]  ACC_RESET       = 8'h00;
  localparam logic [7:0]  PORT_RESET      = 8'hFF;
  localparam logic [2:0]  SP_RESET        = 3'h0;
  localparam logic [2:0]  SP_FULL         = 3'h4;
  // ==========================================================
  // opcode set
  typedef enum logic [5:0] {
    nop_op, add_op, add_carry_op, sub_op, sub_borrow_op, and_op, or_op, xor_op,
    complement_op, rotate_right_op, rotate_left_op, rotate_right_through_carry_op,
    rotate_left_through_carry_op, add_imm_op, sub_imm_op, and_imm_op, or_imm_op, xor_imm_op,
    increment_memory_op, increment_to_accumulator_op, decrement_memory_op,
    decrement_to_accumulator_op, data_transfer_op, data_transfer_to_mem_op, data_transfer_imm_op,
    bit_set_op, bit_clear_op, skip_zero_op, skip_bit_clear_op, skip_bit_set_op,
    unconditional_jump_op, call_op, subroutine_return_op, interrupt_return_op, table_read_op,
    halt_op, wdt_clear_op, wdt_clear_first_op, wdt_clear_second_op
  } mitc_op_e;
endpackage

// ### src/mitc_alu.sv
// file: combinational data path of the instruction timing core
`timescale 1ns/1ps
`default_nettype none
module mitc_alu (
  input  wire mitc_pkg::mitc_op_e op,
  input  wire logic [7:0]         a,
  input  wire logic [7:0]         b,
  input  wire logic               cin,
  input  wire logic [2:0]         bsel,
  output logic [7:0]              res,
  output logic                    c,
  output logic                    ac,
  output logic                    ov,
  output logic                    z,
  output logic                    upd_z,
  output logic                    upd_c,
  output logic                    upd_acov
);
  logic       is_sub;
  logic       is_arith;
  logic       ci;
  logic [7:0] bb;
  logic [7:0] mask;
  logic [8:0] wide;
  logic [4:0] nib;

  // ==========================================================
  // adder shared by add and subtract; subtract is a + ~b + 1, subtract with borrow is a + ~b + carry
  always_comb
  begin
    is_sub   = op inside {mitc_pkg::sub_op, mitc_pkg::sub_borrow_op, mitc_pkg::sub_imm_op};
    is_arith = is_sub || (op inside {mitc_pkg::add_op, mitc_pkg::add_carry_op, mitc_pkg::add_imm_op});
    bb       = is_sub ? ~b : b;
    ci       = (op inside {mitc_pkg::add_carry_op, mitc_pkg::sub_borrow_op}) ? cin : is_sub;
    wide     = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
    nib      = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
    mask     = 8'(8'h01 << bsel);
    res      = b;
    c        = cin;
    upd_z    = 1'b0;
    upd_c    = 1'b0;
    upd_acov = is_arith;
    if (is_arith)
    begin
      res   = wide[7:0];
      c     = wide[8];
      upd_z = 1'b1;
      upd_c = 1'b1;
    end
    unique case (op)
      mitc_pkg::and_op, mitc_pkg::and_imm_op: begin res = a & b; upd_z = 1'b1; end
      mitc_pkg::or_op, mitc_pkg::or_imm_op:   begin res = a | b; upd_z = 1'b1; end
      mitc_pkg::xor_op, mitc_pkg::xor_imm_op: begin res = a ^ b; upd_z = 1'b1; end
      mitc_pkg::complement_op:                begin res = ~b;    upd_z = 1'b1; end
      mitc_pkg::increment_memory_op, mitc_pkg::increment_to_accumulator_op:
      begin
        res   = b + 8'h01;
        upd_z = 1'b1;
      end
      mitc_pkg::decrement_memory_op, mitc_pkg::decrement_to_accumulator_op:
      begin
        res   = b - 8'h01;
        upd_z = 1'b1;
      end
      mitc_pkg::rotate_right_op: res = {b[0], b[7:1]};
      mitc_pkg::rotate_left_op:  res = {b[6:0], b[7]};
      mitc_pkg::rotate_right_through_carry_op:
      begin
        res   = {cin, b[7:1]};
        c     = b[0];
        upd_c = 1'b1;
      end
      mitc_pkg::rotate_left_through_carry_op:
      begin
        res   = {b[6:0], cin};
        c     = b[7];
        upd_c = 1'b1;
      end
      mitc_pkg::data_transfer_to_mem_op: res = a;
      mitc_pkg::bit_set_op:   res = b | mask;
      mitc_pkg::bit_clear_op: res = b & ~mask;
      default: ;
    endcase
    z  = (res == 8'h00);
    ac = nib[4];
    ov = (a[7] == bb[7]) && (wide[7] != a[7]);
  end
endmodule
`default_nettype wire

// ### src/mitc_core.sv
// file: instruction sequencer, register state and cycle timing of the core
`timescale 1ns/1ps
`default_nettype none
module mitc_core (
  input  wire logic        clock,
  input  wire logic        rst,
  output logic [10:0]      prog_addr,
  output logic             prog_fetch,
  input  wire logic [16:0] prog_data,
  input  wire logic [7:0]  port_in,
  input  wire logic        wake,
  input  wire logic        wdt_two_step,
  output logic [7:0]       port_out,
  output logic [7:0]       acc,
  output logic [10:0]      pc,
  output logic             flag_z,
  output logic             flag_c,
  output logic             flag_ac,
  output logic             flag_ov,
  output logic             halted,
  output logic             int_enable,
  output logic             wdt_clear,
  output logic             cycle_end,
  output logic             instr_exec
);
  logic [1:0]         phase, next_phase;
  logic               flush, next_flush;
  logic               tbl_cycle, next_tbl;
  logic [7:0]         tblh, next_tblh;
  logic [2:0]         sp, next_sp;
  logic               wdt_first, next_wdt_first;
  logic               wdt_second, next_wdt_second;
  logic [7:0]         next_acc, next_port;
  logic [10:0]        next_pc;
  logic               next_z, next_c, next_ac, next_ov;
  logic               next_halted, next_int_en, next_wdt_clear;
  logic [7:0]         mem [0:mitc_pkg::MEM_DEPTH-1];
  logic [10:0]        stack [0:mitc_pkg::STACK_DEPTH-1];
  logic               mem_we, stk_we, write_acc, write_mem;
  logic [7:0]         mem_rd, alu_b, alu_res;
  logic               alu_c, alu_ac, alu_ov, alu_z, upd_z, upd_c, upd_acov;
  logic               skip_taken;
  logic [1:0]         top_idx;
  logic [10:0]        pc_inc, pc_skip;
  mitc_pkg::mitc_op_e op;
  logic [5:0]         addr;
  logic [2:0]         bsel;
  logic [7:0]         imm;
  logic               to_mem;

  // ==========================================================
  // decode
  assign op         = mitc_pkg::mitc_op_e'(prog_data[16:mitc_pkg::OP_LSB]);
  assign addr       = prog_data[5:0];
  assign imm        = prog_data[7:0];
  assign bsel       = prog_data[10:mitc_pkg::BIT_LSB];
  assign to_mem     = prog_data[mitc_pkg::DEST_POS];
  assign pc_inc     = pc + 11'h001;
  assign pc_skip    = pc + 11'h002;
  assign top_idx    = 2'(sp - 3'h1);
  assign cycle_end  = (phase == mitc_pkg::PHASE_LAST);
  assign instr_exec = cycle_end && !flush && !halted;
  assign prog_fetch = !halted;
  // the table cycle borrows the program bus, which is why it costs a second cycle
  assign prog_addr  = tbl_cycle ? {mitc_pkg::TABLE_PAGE, mem[mitc_pkg::ADDR_TABLE_PTR]} : pc;
  assign alu_b      = (op inside {mitc_pkg::add_imm_op, mitc_pkg::sub_imm_op, mitc_pkg::and_imm_op,
                       mitc_pkg::or_imm_op, mitc_pkg::xor_imm_op, mitc_pkg::data_transfer_imm_op}) ? imm : mem_rd;

  always_comb
  begin
    unique case (addr)
      mitc_pkg::ADDR_PROGRAM_COUNTER_LOW_BYTE: mem_rd = pc[7:0];
      mitc_pkg::ADDR_PORT:                     mem_rd = port_in;
      mitc_pkg::ADDR_TABLE_HIGH:               mem_rd = tblh;
      default:                                 mem_rd = mem[addr];
    endcase
    skip_taken = (op == mitc_pkg::skip_zero_op && mem_rd == 8'h00) ||
                 (op == mitc_pkg::skip_bit_clear_op && !mem_rd[bsel]) ||
                 (op == mitc_pkg::skip_bit_set_op && mem_rd[bsel]);
  end

  mitc_alu u_alu (
    .op       (op),
    .a        (acc),
    .b        (alu_b),
    .cin      (flag_c),
    .bsel     (bsel),
    .res      (alu_res),
    .c        (alu_c),
    .ac       (alu_ac),
    .ov       (alu_ov),
    .z        (alu_z),
    .upd_z    (upd_z),
    .upd_c    (upd_c),
    .upd_acov (upd_acov)
  );

  // ==========================================================
  // sequencer: all effects land on the last clock of an instruction cycle
  always_comb
  begin
    next_phase      = phase + 2'h1;
    next_flush      = flush;
    next_tbl        = tbl_cycle;
    next_tblh       = tblh;
    next_sp         = sp;
    next_acc        = acc;
    next_pc         = pc;
    next_port       = port_out;
    next_z          = flag_z;
    next_c          = flag_c;
    next_ac         = flag_ac;
    next_ov         = flag_ov;
    next_halted     = halted;
    next_int_en     = int_enable;
    next_wdt_first  = wdt_first;
    next_wdt_second = wdt_second;
    next_wdt_clear  = 1'b0;
    write_acc       = 1'b0;
    write_mem       = 1'b0;
    mem_we          = 1'b0;
    stk_we          = 1'b0;
    if (cycle_end)
    begin
      if (halted)
      begin
        if (wake)
          next_halted = 1'b0;
      end
      else if (flush)
      begin
        // dummy cycle: redirect refill, or the table fetch itself
        next_flush = 1'b0;
        next_tbl   = 1'b0;
        if (tbl_cycle)
        begin
          next_acc  = prog_data[7:0];
          next_tblh = prog_data[15:8];
        end
      end
      else
      begin
        next_pc = pc_inc;
        unique case (op)
          mitc_pkg::add_op, mitc_pkg::add_carry_op, mitc_pkg::sub_op, mitc_pkg::sub_borrow_op,
          mitc_pkg::and_op, mitc_pkg::or_op, mitc_pkg::xor_op, mitc_pkg::complement_op,
          mitc_pkg::rotate_right_op, mitc_pkg::rotate_left_op,
          mitc_pkg::rotate_right_through_carry_op, mitc_pkg::rotate_left_through_carry_op:
          begin
            write_mem = to_mem;
            write_acc = !to_mem;
          end
          mitc_pkg::add_imm_op, mitc_pkg::sub_imm_op, mitc_pkg::and_imm_op, mitc_pkg::or_imm_op,
          mitc_pkg::xor_imm_op, mitc_pkg::increment_to_accumulator_op,
          mitc_pkg::decrement_to_accumulator_op, mitc_pkg::data_transfer_op,
          mitc_pkg::data_transfer_imm_op:
            write_acc = 1'b1;
          mitc_pkg::increment_memory_op, mitc_pkg::decrement_memory_op,
          mitc_pkg::data_transfer_to_mem_op, mitc_pkg::bit_set_op, mitc_pkg::bit_clear_op:
            write_mem = 1'b1;
          mitc_pkg::skip_zero_op, mitc_pkg::skip_bit_clear_op, mitc_pkg::skip_bit_set_op:
            if (skip_taken)
            begin
              next_pc    = pc_skip;
              next_flush = 1'b1;
            end
          mitc_pkg::unconditional_jump_op:
          begin
            next_pc    = prog_data[10:0];
            next_flush = 1'b1;
          end
          mitc_pkg::call_op:
          begin
            next_pc    = prog_data[10:0];
            next_flush = 1'b1;
            // a full stack drops the push; the return then goes astray
            if (sp != mitc_pkg::SP_FULL)
            begin
              stk_we  = 1'b1;
              next_sp = sp + 3'h1;
            end
          end
          mitc_pkg::subroutine_return_op, mitc_pkg::interrupt_return_op:
          begin
            next_pc    = stack[top_idx];
            next_flush = 1'b1;
            if (sp != mitc_pkg::SP_RESET)
              next_sp = sp - 3'h1;
            if (op == mitc_pkg::interrupt_return_op)
              next_int_en = 1'b1;
          end
          mitc_pkg::table_read_op:
          begin
            next_flush = 1'b1;
            next_tbl   = 1'b1;
          end
          mitc_pkg::halt_op:
          begin
            next_halted     = 1'b1;
            next_wdt_clear  = 1'b1;
            next_wdt_first  = 1'b0;
            next_wdt_second = 1'b0;
          end
          mitc_pkg::wdt_clear_op:
            next_wdt_clear = !wdt_two_step;
          mitc_pkg::wdt_clear_first_op, mitc_pkg::wdt_clear_second_op:
            if (wdt_two_step)
            begin
              // clear only once both halves are seen; repeats of one half do nothing
              if ((op == mitc_pkg::wdt_clear_first_op) ? wdt_second : wdt_first)
              begin
                next_wdt_clear  = 1'b1;
                next_wdt_first  = 1'b0;
                next_wdt_second = 1'b0;
              end
              else if (op == mitc_pkg::wdt_clear_first_op)
                next_wdt_first = 1'b1;
              else
                next_wdt_second = 1'b1;
            end
          default: ;
        endcase
        if (upd_z)
          next_z = alu_z;
        if (upd_c)
          next_c = alu_c;
        if (upd_acov)
        begin
          next_ac = alu_ac;
          next_ov = alu_ov;
        end
        if (write_acc)
          next_acc = alu_res;
        if (write_mem)
        begin
          mem_we = 1'b1;
          if (addr == mitc_pkg::ADDR_PROGRAM_COUNTER_LOW_BYTE)
          begin
            next_pc    = {pc[10:8], alu_res};
            next_flush = 1'b1;
          end
          if (addr == mitc_pkg::ADDR_PORT)
            next_port = alu_res;
        end
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      phase      <= mitc_pkg::PHASE_FIRST;
      flush      <= 1'b0;
      tbl_cycle  <= 1'b0;
      tblh       <= mitc_pkg::ACC_RESET;
      sp         <= mitc_pkg::SP_RESET;
      acc        <= mitc_pkg::ACC_RESET;
      pc         <= mitc_pkg::PC_RESET;
      port_out   <= mitc_pkg::PORT_RESET;
      flag_z     <= 1'b0;
      flag_c     <= 1'b0;
      flag_ac    <= 1'b0;
      flag_ov    <= 1'b0;
      halted     <= 1'b0;
      int_enable <= 1'b0;
      wdt_first  <= 1'b0;
      wdt_second <= 1'b0;
      wdt_clear  <= 1'b0;
    end
    else
    begin
      phase      <= next_phase;
      flush      <= next_flush;
      tbl_cycle  <= next_tbl;
      tblh       <= next_tblh;
      sp         <= next_sp;
      acc        <= next_acc;
      pc         <= next_pc;
      port_out   <= next_port;
      flag_z     <= next_z;
      flag_c     <= next_c;
      flag_ac    <= next_ac;
      flag_ov    <= next_ov;
      halted     <= next_halted;
      int_enable <= next_int_en;
      wdt_first  <= next_wdt_first;
      wdt_second <= next_wdt_second;
      wdt_clear  <= next_wdt_clear;
    end
  end

  // data memory and return stack carry no reset, like ordinary ram
  always_ff @(posedge clock)
  begin
    if (mem_we)
      mem[addr] <= alu_res;
    if (stk_we)
      stack[sp[1:0]] <= pc_inc;
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_cycle_four:   assert property (cycle_end |=> !cycle_end [*3] ##1 cycle_end)
    else $error("instruction cycle not four clocks");
  a_single_cycle: assert property (instr_exec && !next_flush && !next_halted |-> ##4 instr_exec)
    else $error("plain instruction took more than one cycle");
  a_branch_extra: assert property (instr_exec &&
    (op inside {mitc_pkg::unconditional_jump_op, mitc_pkg::call_op, mitc_pkg::subroutine_return_op,
    mitc_pkg::interrupt_return_op}) |=> !instr_exec [*7] ##1 instr_exec)
    else $error("branch did not take exactly two cycles");
  a_low_byte_jump: assert property (instr_exec && mem_we &&
    addr == mitc_pkg::ADDR_PROGRAM_COUNTER_LOW_BYTE |=> pc[7:0] == $past(alu_res) && flush)
    else $error("low byte write did not redirect");
  a_skip_extra:   assert property (instr_exec && skip_taken |=> (pc == $past(pc_skip)) ##7 instr_exec)
    else $error("taken skip timing wrong");
  a_skip_none:    assert property (instr_exec && !skip_taken &&
    (op inside {mitc_pkg::skip_zero_op, mitc_pkg::skip_bit_clear_op, mitc_pkg::skip_bit_set_op})
    |=> pc == $past(pc_inc))
    else $error("untaken skip moved wrongly");
  a_add_carry:    assert property (instr_exec && (op inside {mitc_pkg::add_op, mitc_pkg::add_imm_op})
    |=> flag_c == ({1'b0, $past(acc)} + {1'b0, $past(alu_b)} > 9'h0FF))
    else $error("add carry wrong");
  a_inc_by_one:   assert property (instr_exec && op == mitc_pkg::increment_to_accumulator_op
    |=> acc == $past(mem_rd) + 8'h01)
    else $error("increment not by one");
  a_logic_zero:   assert property (instr_exec &&
    (op inside {mitc_pkg::and_imm_op, mitc_pkg::or_imm_op, mitc_pkg::xor_imm_op}) |=> flag_z == (acc == 8'h00))
    else $error("zero flag disagrees with result");
  a_rotate_carry: assert property (instr_exec && op == mitc_pkg::rotate_left_through_carry_op && !to_mem
    |=> flag_c == $past(mem_rd[7]) && acc[0] == $past(flag_c))
    else $error("rotate through carry wrong");
  a_call_saves:   assert property (instr_exec && op == mitc_pkg::call_op && sp != mitc_pkg::SP_FULL
    |=> stack[top_idx] == $past(pc_inc))
    else $error("call saved wrong address");
  a_bit_only:     assert property (instr_exec && op == mitc_pkg::bit_set_op
    |=> mem[$past(addr)] == ($past(mem_rd) | 8'(8'h01 << $past(bsel))))
    else $error("bit set touched other bits");
  a_table_data:   assert property (cycle_end && flush && tbl_cycle |=> acc == $past(prog_data[7:0]))
    else $error("table data not delivered");
  a_transfer_imm: assert property (instr_exec && op == mitc_pkg::data_transfer_imm_op |=> acc == $past(imm))
    else $error("immediate transfer wrong");
  a_halt_stops:   assert property (halted && !wake |=> !instr_exec)
    else $error("executed while halted");

  c_call:  cover property (instr_exec && op == mitc_pkg::call_op);
  c_skip:  cover property (instr_exec && skip_taken);
  c_table: cover property (cycle_end && flush && tbl_cycle);
  c_wake:  cover property (halted && wake && cycle_end);
endmodule
`default_nettype wire

// ### test/mitc_core_tb.sv
// self-checking testbench of the instruction timing core
`timescale 1ns/1ps
`default_nettype none
module mitc_core_tb;
  logic        clock;
  logic        rst;
  logic [16:0] prog_data;
  logic [7:0]  port_in;
  logic        wake;
  logic        wdt_two_step;
  logic [10:0] prog_addr;
  logic [7:0]  port_out;
  logic [7:0]  acc;
  logic [10:0] pc;
  logic        flag_z;
  logic        flag_c;
  logic        halted;
  logic        wdt_clear;
  logic        instr_exec;
  logic        prog_fetch;
  logic        flag_ac;
  logic        flag_ov;
  logic        int_enable;
  logic        cycle_end;
  logic [16:0] rom [0:2047];
  int          mismatches = 0;
  int          checked = 0;
  // ==========================================================
  // clock, program memory and design
  initial clock = 1'b0;
  always #25 clock = ~clock;
  initial prog_data = '0;
  // async rom model, refreshed off the sampling edge
  always @(negedge clock) prog_data <= rom[prog_addr];
  mitc_core uut (
    .clock(clock), .rst(rst), .prog_addr(prog_addr), .prog_fetch(prog_fetch), .prog_data(prog_data),
    .port_in(port_in), .wake(wake), .wdt_two_step(wdt_two_step), .port_out(port_out),
    .acc(acc), .pc(pc), .flag_z(flag_z), .flag_c(flag_c), .flag_ac(flag_ac), .flag_ov(flag_ov),
    .halted(halted), .int_enable(int_enable), .wdt_clear(wdt_clear), .cycle_end(cycle_end),
    .instr_exec(instr_exec)
  );
  // ==========================================================
  // shared tasks
  task automatic report_and_stop;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string m);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic p(input int a, input mitc_pkg::mitc_op_e o, input logic [10:0] f);
    rom[a] = {6'(o), f};
  endtask
  // program is loaded while reset holds
  task automatic go;
    @(negedge clock);
    rst = 1'b1;
    foreach (rom[i]) rom[i] = '0;
  endtask
  task automatic release_rst;
    repeat (10) @(negedge clock);
    rst = 1'b0;
  endtask
  // waits for an executing cycle; gap 0 means the spacing is not judged
  task automatic step(input logic [10:0] pc_e, input int gap);
    int n;
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
    end
    while (instr_exec !== 1'b1 && n < 40);
    chk(11'({cycle_end, instr_exec}), 11'h003, "cycle end with exec");
    chk(pc, pc_e, "pc");
    if (gap != 0)
      chk(11'(n), 11'(gap), "clocks between executions");
  endtask
  // ==========================================================
  // scenarios
  task automatic arith_branch;
    go;
    p(0, mitc_pkg::data_transfer_imm_op, 11'h0F0);
    p(1, mitc_pkg::data_transfer_to_mem_op, 11'h010);
    p(2, mitc_pkg::add_imm_op, 11'h020);
    p(3, mitc_pkg::sub_imm_op, 11'h011);
    p(4, mitc_pkg::unconditional_jump_op, 11'h008);
    p(8, mitc_pkg::call_op, 11'h020);
    p(32, mitc_pkg::increment_to_accumulator_op, 11'h010);
    p(33, mitc_pkg::decrement_memory_op, 11'h010);
    p(34, mitc_pkg::subroutine_return_op, 11'h000);
    p(9, mitc_pkg::data_transfer_op, 11'h010);
    p(10, mitc_pkg::complement_op, 11'h010);
    p(11, mitc_pkg::and_imm_op, 11'h000);
    release_rst;
    step(11'h000, 3);
    step(11'h001, 4);
    chk(11'(acc), 11'h0F0, "acc");
    step(11'h002, 4);
    step(11'h003, 4);
    chk(11'(acc), 11'h010, "acc");
    chk(11'(flag_c), 11'h001, "carry");
    step(11'h004, 4);
    chk(11'(acc), 11'h0FF, "acc");
    chk(11'(flag_c), 11'h000, "borrow");
    step(11'h008, 8);
    step(11'h020, 8);
    step(11'h021, 4);
    chk(11'(acc), 11'h0F1, "acc");
    step(11'h022, 4);
    step(11'h009, 8);
    step(11'h00A, 4);
    chk(11'(acc), 11'h0EF, "acc");
    step(11'h00B, 4);
    chk(11'(acc), 11'h010, "acc");
    chk(11'(flag_z), 11'h000, "zero");
    step(11'h00C, 4);
    chk(11'(flag_z), 11'h001, "zero");
  endtask
  task automatic skip_bits_table;
    go;
    port_in = 8'h00;
    p(0, mitc_pkg::data_transfer_imm_op, 11'h000);
    p(1, mitc_pkg::data_transfer_to_mem_op, 11'h012);
    p(2, mitc_pkg::bit_set_op, 11'h312);
    p(3, mitc_pkg::skip_zero_op, 11'h012);
    p(5, mitc_pkg::skip_bit_set_op, 11'h012);
    p(6, mitc_pkg::data_transfer_imm_op, 11'h081);
    p(7, mitc_pkg::data_transfer_to_mem_op, 11'h011);
    p(8, mitc_pkg::rotate_left_through_carry_op, 11'h011);
    p(9, mitc_pkg::rotate_right_through_carry_op, 11'h011);
    p(10, mitc_pkg::data_transfer_imm_op, 11'h005);
    p(11, mitc_pkg::data_transfer_to_mem_op, 11'h007);
    p(12, mitc_pkg::table_read_op, 11'h000);
    p(13, mitc_pkg::data_transfer_imm_op, 11'h020);
    p(14, mitc_pkg::data_transfer_to_mem_op, 11'h002);
    rom[11'h705] = 17'h03C5A;
    release_rst;
    step(11'h000, 3);
    step(11'h001, 4);
    chk(11'(port_out), 11'h0FF, "port reset");
    step(11'h002, 4);
    step(11'h003, 4);
    chk(11'(port_out), 11'h008, "port");
    step(11'h005, 8);
    step(11'h006, 4);
    step(11'h007, 4);
    step(11'h008, 4);
    step(11'h009, 4);
    chk(11'(acc), 11'h002, "acc");
    chk(11'(flag_c), 11'h001, "carry");
    step(11'h00A, 4);
    chk(11'(acc), 11'h0C0, "acc");
    step(11'h00B, 4);
    step(11'h00C, 4);
    // one clock into the table cycle; seven more to the next execution
    @(negedge clock);
    chk(prog_addr, 11'h705, "table address");
    step(11'h00D, 7);
    chk(11'(acc), 11'h05A, "table");
    step(11'h00E, 4);
    step(11'h020, 8);
  endtask
  task automatic halt_wake;
    go;
    p(0, mitc_pkg::wdt_clear_op, 11'h000);
    p(1, mitc_pkg::halt_op, 11'h000);
    p(2, mitc_pkg::data_transfer_imm_op, 11'h033);
    release_rst;
    step(11'h000, 3);
    @(negedge clock);
    chk(11'(wdt_clear), 11'h001, "wdt pulse");
    step(11'h001, 3);
    @(negedge clock);
    chk(11'(halted), 11'h001, "halted");
    chk(11'(wdt_clear), 11'h001, "wdt pulse");
    repeat (12) @(negedge clock);
    chk(11'(halted), 11'h001, "halted");
    chk(11'(prog_fetch), 11'h000, "fetch stopped");
    wake = 1'b1;
    step(11'h002, 0);
    wake = 1'b0;
    step(11'h003, 4);
    chk(11'(acc), 11'h033, "acc");
    chk(11'(prog_fetch), 11'h001, "fetch running");
  endtask
  task automatic wdt_pair;
    wdt_two_step = 1'b1;
    go;
    p(0, mitc_pkg::wdt_clear_first_op, 11'h000);
    p(1, mitc_pkg::wdt_clear_first_op, 11'h000);
    p(2, mitc_pkg::wdt_clear_second_op, 11'h000);
    release_rst;
    step(11'h000, 3);
    @(negedge clock);
    chk(11'(wdt_clear), 11'h000, "wdt half");
    step(11'h001, 3);
    @(negedge clock);
    chk(11'(wdt_clear), 11'h000, "wdt repeat");
    step(11'h002, 3);
    @(negedge clock);
    chk(11'(wdt_clear), 11'h001, "wdt pair");
    wdt_two_step = 1'b0;
  endtask
  // 7F+01 sets aux carry and overflow; 80 rotated, bumped, bit 6 cleared gives 01
  task automatic more_ops;
    go;
    p(0, mitc_pkg::data_transfer_imm_op, 11'h07F);
    p(1, mitc_pkg::add_imm_op, 11'h001);
    p(2, mitc_pkg::data_transfer_to_mem_op, 11'h011);
    p(3, mitc_pkg::rotate_left_op, 11'h011);
    p(4, mitc_pkg::rotate_right_op, 11'h111);
    p(5, mitc_pkg::increment_memory_op, 11'h011);
    p(6, mitc_pkg::bit_clear_op, 11'h611);
    p(7, mitc_pkg::skip_bit_clear_op, 11'h111);
    p(8, mitc_pkg::data_transfer_imm_op, 11'h055);
    p(9, mitc_pkg::data_transfer_op, 11'h011);
    p(10, mitc_pkg::xor_imm_op, 11'h0FF);
    p(11, mitc_pkg::or_imm_op, 11'h001);
    p(12, mitc_pkg::call_op, 11'h020);
    p(32, mitc_pkg::interrupt_return_op, 11'h000);
    release_rst;
    step(11'h000, 3);
    step(11'h001, 4);
    step(11'h002, 4);
    chk(11'(acc), 11'h080, "acc");
    chk(11'(flag_ac), 11'h001, "aux carry");
    chk(11'(flag_ov), 11'h001, "overflow");
    step(11'h003, 4);
    step(11'h004, 4);
    chk(11'(acc), 11'h001, "acc");
    step(11'h005, 4);
    step(11'h006, 4);
    step(11'h007, 4);
    step(11'h009, 8);
    step(11'h00A, 4);
    chk(11'(acc), 11'h001, "acc");
    step(11'h00B, 4);
    chk(11'(acc), 11'h0FE, "acc");
    step(11'h00C, 4);
    chk(11'(acc), 11'h0FF, "acc");
    step(11'h020, 8);
    chk(11'(int_enable), 11'h000, "int enable");
    step(11'h00D, 8);
    chk(11'(int_enable), 11'h001, "int enable");
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    rst = 1'b1;
    port_in = 8'h00;
    wake = 1'b0;
    wdt_two_step = 1'b0;
    arith_branch();
    skip_bits_table();
    more_ops();
    halt_wake();
    wdt_pair();
    report_and_stop();
  end
  // all scenarios need well under 1000 clocks; this is a generous margin
  initial
  begin
    repeat (20000) @(posedge clock);
    mismatches++;
    report_and_stop();
  end
endmodule
`default_nettype wire
